/* logic/uart_rx_pkg.sv */
// package: constants, types and register map for the asynchronous receiver
package uart_rx_pkg;
  // register byte offsets on the avalon slave
  localparam logic [3:0] OFS_MODE   = 4'h0;   // serial_mode_reg
  localparam logic [3:0] OFS_DIV    = 4'h4;   // baud_divider and prescale select
  localparam logic [3:0] OFS_BUF    = 4'h8;   // rx_buffer
  localparam logic [3:0] OFS_STATUS = 4'hc;   // rx_error_status_reg, clear on read
  // mode register field positions
  localparam int MODE_CAE_BIT  = 7;           // channel_operation_enable
  localparam int MODE_RXE_BIT  = 5;           // rx_enable
  localparam int MODE_PAR_LSB  = 3;           // parity mode, two bits
  localparam int MODE_LEN_BIT  = 2;           // 1 = 8 data bits, 0 = 7
  localparam int MODE_MRG_BIT  = 0;           // error_irq_merge_sel
  localparam logic [7:0] MODE_RESET = 8'h01;  // merge selector set after reset
  // divider register fields
  localparam int DIV_PRE_LSB = 8;             // prescaler select, four bits
  localparam logic [7:0] DIV_K_RESET = 8'hff; // divisor k after reset
  localparam logic [7:0] DIV_K_MIN   = 8'h08; // smallest legal divisor
  localparam logic [3:0] PRE_MAX     = 4'ha;  // largest legal prescale select
  // status register bit positions
  localparam int ST_OVE_BIT = 0;
  localparam int ST_FE_BIT  = 1;
  localparam int ST_PE_BIT  = 2;
  // parity modes
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } parity_t;
  // control bundle handed to the receive core
  typedef struct packed {
    logic       chanEnable;   // channel_operation_enable
    logic       rxEnable;     // rx_enable
    parity_t    parity;       // parity mode
    logic       eightBits;    // data length
    logic       mergeSel;     // error_irq_merge_sel
    logic [3:0] preSel;       // basic clock prescale
    logic [7:0] divK;         // baud_divider
  } rx_ctrl_t;
  // result bundle handed back by the receive core
  typedef struct packed {
    logic       done;         // one-cycle frame end pulse
    logic       frameErr;     // stop bit missing
    logic       parityErr;    // parity mismatch
    logic [7:0] data;         // received word
  } rx_result_t;
endpackage

/* logic/uart_rx_core.sv */
// file: receive shift engine with noise filter and baud timing
`timescale 1ns/1ps
module uart_rx_core (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire uart_rx_pkg::rx_ctrl_t  ctrl,
  input  wire logic                   serial_rx_input,  // already synchronised
  output uart_rx_pkg::rx_result_t     result
);
  import uart_rx_pkg::*;

  typedef enum {IDLE, START, DATA, PARITY, STOP} rx_state_t;

  logic [10:0] preCnt_q;      // prescaler counter
  logic        basicTick;     // one pulse per basic clock rising edge
  logic        filtA_q;       // first filter sample
  logic        filtB_q;       // second filter sample
  logic        line_q;        // filtered line
  logic [7:0]  baudCnt_q;     // half-bit counter
  logic        halfTick;      // half bit period elapsed
  logic        phase_q;       // toggles each half bit, sample on 1
  rx_state_t   state_q;
  logic [2:0]  bitIdx_q;      // data bit index
  logic [7:0]  shift_q;       // reception shift register
  logic        parAcc_q;      // running xor of data and parity
  logic        active;        // receiver running

  assign active = ctrl.chanEnable && ctrl.rxEnable;

  // prescaler: basic clock held low while channel is off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_q <= 11'h000;
    end else if (!ctrl.chanEnable) begin
      preCnt_q <= 11'h000;
    end else begin
      preCnt_q <= preCnt_q + 11'h001;
    end
  end
  // tick when the selected power-of-two divider wraps
  always_comb begin
    logic [10:0] mask;
    mask      = 11'h000;
    mask      = (11'h001 << ctrl.preSel) - 11'h001;
    basicTick = ctrl.chanEnable && ((preCnt_q & mask) == mask);
  end

  // two-sample match noise filter on the basic clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filtA_q <= 1'b1;
      filtB_q <= 1'b1;
      line_q  <= 1'b1;
    end else if (basicTick) begin
      filtA_q <= serial_rx_input;
      filtB_q <= filtA_q;
      if (filtA_q == filtB_q) begin
        line_q <= filtB_q;
      end
    end
  end

  // baud timing: half bit = k basic clocks, bit = 2k
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_q <= 8'h00;
    end else if (state_q == IDLE || halfTick) begin
      baudCnt_q <= 8'h00;
    end else if (basicTick) begin
      baudCnt_q <= baudCnt_q + 8'h01;
    end
  end
  assign halfTick = basicTick && (baudCnt_q == ctrl.divK - 8'h01);

  // frame state machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= IDLE;
      phase_q   <= 1'b0;
      bitIdx_q  <= 3'h0;
      shift_q   <= 8'h00;
      parAcc_q  <= 1'b0;
      result    <= '0;
    end else begin
      result.done <= 1'b0;
      if (!active) begin
        state_q <= IDLE;
        phase_q <= 1'b0;
      end else begin
        unique case (state_q)
          // wait for a falling line
          IDLE: begin
            if (basicTick && !line_q) begin
              state_q <= START;
              phase_q <= 1'b0;
            end
          end
          // recheck start at mid bit
          START: begin
            if (halfTick) begin
              if (line_q) begin
                state_q <= IDLE;  // glitch, not a start
              end else begin
                state_q  <= DATA;
                phase_q  <= 1'b0;
                bitIdx_q <= 3'h0;
                parAcc_q <= 1'b0;
              end
            end
          end
          // data, lsb first
          DATA: begin
            if (halfTick) begin
              phase_q <= ~phase_q;
              if (phase_q) begin
                shift_q  <= {line_q, shift_q[7:1]};
                parAcc_q <= parAcc_q ^ line_q;
                bitIdx_q <= bitIdx_q + 3'h1;
                if (bitIdx_q == {2'h3, ctrl.eightBits}) begin
                  state_q <= (ctrl.parity == PAR_NONE) ? STOP : PARITY;
                end
              end
            end
          end
          // parity bit: never aborts the frame
          PARITY: begin
            if (halfTick) begin
              phase_q <= ~phase_q;
              if (phase_q) begin
                parAcc_q <= parAcc_q ^ line_q;
                state_q  <= STOP;
              end
            end
          end
          // stop bit closes the frame
          STOP: begin
            if (halfTick) begin
              phase_q <= ~phase_q;
              if (phase_q) begin
                state_q          <= IDLE;
                result.done      <= 1'b1;
                result.frameErr  <= !line_q;
                result.data      <= ctrl.eightBits ? shift_q : {1'b0, shift_q[7:1]};
                unique case (ctrl.parity)
                  PAR_EVEN: result.parityErr <= parAcc_q;
                  PAR_ODD:  result.parityErr <= !parAcc_q;
                  default:  result.parityErr <= 1'b0;
                endcase
              end
            end
          end
        endcase
      end
    end
  end
endmodule

/* logic/uart_async_receiver.sv */
// file: receiver top with avalon register slave, buffer, status and interrupts
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Contract
// - disabled receiver idles, buffer kept, no interrupts
// - frame starts only on detected start bit
// - stop bit raises done and loads buffer
// - overrun keeps buffer, interrupt per selector
// - parity/framing errors finish frame then interrupt
// - clearing enable mid-frame aborts silently
// - error flag set with selected interrupt
// - status read returns flags then clears
// - selector 0 error irq, 1 done irq
// - missing stop bit flags framing error
// - unread buffer plus new frame flags overrun
// - even parity: odd ones count errors
// - odd parity: even ones count errors
// - zero parity never flags parity error
// - no parity bit, never parity error
// - two matching samples pass filter
// - filter delays line up to three basic clocks
// - basic clock stopped while channel disabled
// - bit rate is basic clock over 2k
module uart_async_receiver (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        serial_rx_line,    // receive pin
  output logic             rx_done_irq,       // one-cycle pulse
  output logic             rx_error_irq       // one-cycle pulse
);
  import uart_rx_pkg::*;

  logic [7:0]  mode_q;        // serial_mode_reg
  logic [7:0]  divK_q;        // baud_divider
  logic [3:0]  preSel_q;      // prescale select
  logic [7:0]  rxBuf_q;       // rx_buffer
  logic        bufFull_q;     // buffer holds an unread word
  logic [2:0]  status_q;      // rx_error_status_reg
  logic        sync1_q;       // pin synchroniser stage 1
  logic        sync2_q;       // pin synchroniser stage 2
  logic        ack_q;         // one-cycle bus answer
  logic        rdHit;         // accepted read this cycle
  logic        wrHit;         // accepted write this cycle
  logic        overrun;       // frame ends on unread buffer
  logic        anyErr;        // any error at frame end
  rx_ctrl_t    ctrl;
  rx_result_t  res;

  // register map check: an offset decoder reused for read and write
  function automatic logic isMapped(input logic [3:0] a);
    isMapped = (a == OFS_MODE) || (a == OFS_DIV) || (a == OFS_BUF) || (a == OFS_STATUS);
  endfunction

  // control bundle
  always_comb begin
    ctrl.chanEnable = mode_q[MODE_CAE_BIT];
    ctrl.rxEnable   = mode_q[MODE_RXE_BIT];
    ctrl.parity     = parity_t'(mode_q[MODE_PAR_LSB +: 2]);
    ctrl.eightBits  = mode_q[MODE_LEN_BIT];
    ctrl.mergeSel   = mode_q[MODE_MRG_BIT];
    ctrl.preSel     = preSel_q;
    ctrl.divK       = divK_q;
  end

  // two-flop synchroniser on the receive pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= serial_rx_line;
      sync2_q <= sync1_q;
    end
  end

  uart_rx_core u_core (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .ctrl            (ctrl),
    .serial_rx_input (sync2_q),
    .result          (res)
  );

  // bus handshake: every access waits exactly one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign rdHit = avs_read && ack_q;
  assign wrHit = avs_write && ack_q;

  // read data and response registered at the waiting cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if ((avs_read || avs_write) && !ack_q) begin
      avs_response <= isMapped(avs_address) ? 2'h0 : 2'h3;  // decodeerror
      avs_readdata <= 32'h00000000;
      if (avs_read) begin
        unique case (avs_address)
          OFS_MODE:   avs_readdata <= {24'h000000, mode_q};
          OFS_DIV:    avs_readdata <= {20'h00000, preSel_q, divK_q};
          OFS_BUF:    avs_readdata <= {24'h000000, rxBuf_q};
          OFS_STATUS: avs_readdata <= {29'h00000000, status_q};
          default:    avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // mode register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
    end else if (wrHit && avs_address == OFS_MODE && avs_byteenable[0]) begin
      mode_q <= avs_writedata[7:0];
    end
  end

  // divider register writes, illegal values ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divK_q   <= DIV_K_RESET;
      preSel_q <= 4'h0;
    end else if (wrHit && avs_address == OFS_DIV) begin
      if (avs_byteenable[0] && avs_writedata[7:0] >= DIV_K_MIN) begin
        divK_q <= avs_writedata[7:0];
      end
      if (avs_byteenable[1] && avs_writedata[DIV_PRE_LSB +: 4] <= PRE_MAX) begin
        preSel_q <= avs_writedata[DIV_PRE_LSB +: 4];
      end
    end
  end

  assign overrun = res.done && bufFull_q && !(rdHit && avs_address == OFS_BUF);
  assign anyErr  = res.done && (overrun || res.frameErr || res.parityErr);

  // receive buffer: loaded at stop unless overrun
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q <= 8'h00;
    end else if (res.done && !overrun) begin
      rxBuf_q <= res.data;
    end
  end

  // buffer full flag: new word wins over a read in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufFull_q <= 1'b0;
    end else if (res.done) begin
      bufFull_q <= 1'b1;
    end else if (rdHit && avs_address == OFS_BUF) begin
      bufFull_q <= 1'b0;
    end
  end

  // error status: set wins over the clearing read; a read clears only the flags it returned,
  // so a flag set between the data capture and the accepting edge is not lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 3'h0;
    end else begin
      if (rdHit && avs_address == OFS_STATUS) begin
        status_q <= status_q & ~avs_readdata[2:0];
      end
      if (res.done) begin
        if (overrun) status_q[ST_OVE_BIT] <= 1'b1;
        if (res.frameErr) status_q[ST_FE_BIT] <= 1'b1;
        if (res.parityErr) status_q[ST_PE_BIT] <= 1'b1;
      end
    end
  end

  // interrupt pulses, registered with the status update
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_done_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      rx_done_irq  <= res.done && (!anyErr || ctrl.mergeSel);
      rx_error_irq <= anyErr && !ctrl.mergeSel;
    end
  end
endmodule

/* verif/uart_async_receiver_props.sv */
// checker: port-level properties of the asynchronous receiver
`timescale 1ns/1ps
module uart_async_receiver_props
  import uart_rx_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        serial_rx_line,
  input wire logic        rx_done_irq,
  input wire logic        rx_error_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire  anyIrq = rx_done_irq || rx_error_irq;  // either interrupt pulse
  wire  stRd   = avs_read && !avs_waitrequest && avs_address == OFS_STATUS;  // status read taken
  logic clrSeen_q;                              // status read since the last interrupt
  logic [7:0] gap_q;                            // cycles since the last interrupt, saturating
  // a pending flag always comes with an interrupt, so a read clears the view
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) clrSeen_q <= 1'b0;
    else if (anyIrq) clrSeen_q <= 1'b0;
    else if (stRd) clrSeen_q <= 1'b1;
  end
  // distance between interrupts; a frame is far longer than the bound
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 8'hff;
    else if (anyIrq) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered in its first cycle");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  irq_excl_a: assert property (!(rx_done_irq && rx_error_irq))
    else $error("both interrupts at once");
  done_pulse_a: assert property (rx_done_irq |=> !rx_done_irq)
    else $error("done interrupt longer than one cycle");
  err_pulse_a: assert property (rx_error_irq |=> !rx_error_irq)
    else $error("error interrupt longer than one cycle");
  irq_gap_a: assert property (anyIrq |-> gap_q >= 8'h64)
    else $error("interrupts closer than one frame");
  clr_read_a: assert property (stRd && clrSeen_q && !anyIrq |-> avs_readdata == 32'h0)
    else $error("status not cleared by read");
  decode_err_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  done_c: cover property (rx_done_irq);
  err_c: cover property (rx_error_irq);
  status_c: cover property (stRd && clrSeen_q);
endmodule
bind uart_async_receiver uart_async_receiver_props props (.sys_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
  .serial_rx_line, .rx_done_irq, .rx_error_irq);

/* verif/uart_tx_model.sv */
// model of the remote serial transmitter on the receive line
`timescale 1ns/1ps
module uart_tx_model #(
  parameter int BIT_CYC = 16  // sys_clk cycles per bit
) (
  input wire logic sys_clk,
  output logic     serial_rx_line
);
  import uart_rx_pkg::*;
  initial serial_rx_line = 1'b1;  // line idles high
  // hold one level for a whole bit time; spikes adds one-clock inverted pulses every third clock
  task automatic put(input logic b, input logic spikes);
    for (int c = 0; c < BIT_CYC; c++) begin
      serial_rx_line <= (spikes && c % 3 == 2) ? !b : b;
      @(posedge sys_clk);
    end
  endtask
  // one frame; flipPar and badStop corrupt it on purpose
  task automatic send(input logic [7:0] d, input parity_t par, input logic flipPar, input logic badStop,
                      input logic spikes);
    logic p;
    p = (par == PAR_EVEN) ? ^d : (par == PAR_ODD) ? ~^d : 1'b0;
    put(1'b0, spikes);                                        // start bit
    for (int i = 0; i < 8; i++) put(d[i], spikes);
    if (par != PAR_NONE) put(p ^ flipPar, spikes);
    put(!badStop, spikes);                                    // stop bit
    serial_rx_line <= 1'b1;
    @(posedge sys_clk);  // one idle clock keeps back-to-back frames apart
  endtask
  // a low pulse one clock wide
  task automatic glitch();
    serial_rx_line <= 1'b0;
    @(posedge sys_clk);
    serial_rx_line <= 1'b1;
  endtask
endmodule

/* verif/uart_async_receiver_tb.sv */
// self-checking bench for the asynchronous receiver
`timescale 1ns/1ps
module uart_async_receiver_tb;
  import uart_rx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        serial_rx_line;
  logic        rx_done_irq;
  logic        rx_error_irq;
  logic [32:0] rdQ[$];          // {check, expected read data}
  logic [1:0]  irqQ[$];         // expected {done, error}
  int          bad_count = 0;
  int          samples_checked = 0;
  int          irqSeen = 0;
  logic        spikes = 1'b0;   // next frame carries filtered noise
  always #12.5 sys_clk = ~sys_clk;
  uart_async_receiver uut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response, .serial_rx_line,
    .rx_done_irq, .rx_error_irq);
  uart_tx_model #(.BIT_CYC(16)) tx (.sys_clk, .serial_rx_line);
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // compare a finished read against the oldest note
  task automatic cmp_rd(input logic [32:0] e);
    samples_checked++;
    if (e[32] && avs_readdata !== e[31:0]) begin
      bad_count++;
      $display("MISMATCH %0t read %h expected %h", $time, avs_readdata, e[31:0]);
    end
  endtask
  // compare an interrupt pulse against the oldest note
  task automatic cmp_irq();
    logic [1:0] e;
    e = (irqQ.size() != 0) ? irqQ.pop_front() : 2'h0;
    samples_checked++;
    irqSeen++;
    if ({rx_done_irq, rx_error_irq} !== e) begin
      bad_count++;
      $display("MISMATCH %0t irq %b expected %b", $time, {rx_done_irq, rx_error_irq}, e);
    end
  endtask
  // read data is taken at the rising edge where waitrequest is seen low
  always @(posedge sys_clk) begin
    if (avs_read && !avs_waitrequest) cmp_rd(rdQ.pop_front());
  end
  // interrupt pulses are watched mid-cycle, where they are settled
  always @(negedge sys_clk) begin
    if (rx_done_irq || rx_error_irq) cmp_irq();
  end
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);  // one idle edge between transfers
  endtask
  // read with an expected value; chk low only drains
  task automatic rd(input logic [3:0] a, input logic chk, input logic [31:0] e);
    rdQ.push_back({chk, e});
    bus(1'b1, a, 32'h0);
  endtask
  // mode write: channel on, eight data bits
  task automatic md(input parity_t p, input logic m, input logic e);
    bus(1'b0, OFS_MODE, {24'h0, 1'b1, 1'b0, e, p, 1'b1, 1'b0, m});
  endtask
  // send a frame and wait, bounded, for the expected interrupt
  task automatic frame(input logic [7:0] d, input parity_t p, input logic fp, input logic bs,
                       input logic [1:0] irq);
    int tgt;
    tgt = irqSeen + ((irq != 2'h0) ? 1 : 0);
    if (irq != 2'h0) irqQ.push_back(irq);
    tx.send(d, p, fp, bs, spikes);
    repeat (100) if (irqSeen < tgt) @(posedge sys_clk);
  endtask
  initial begin
    logic [7:0] d;
    logic       bad;
    void'($urandom(32'hc36a));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFS_MODE, 1'b1, 32'h01);
    rd(OFS_DIV, 1'b1, 32'hff);
    bus(1'b0, OFS_DIV, 32'h04);                          // divisor below minimum is refused
    rd(OFS_DIV, 1'b1, 32'hff);
    bus(1'b0, OFS_DIV, 32'h08);                          // sixteen clocks a bit
    rd(OFS_DIV, 1'b1, 32'h08);
    rd(4'h2, 1'b1, 32'h0);
    bus(1'b0, OFS_MODE, 32'h81);
    for (int p = 0; p < 4; p++) begin
      d = 8'($urandom);
      bad = (p >= 2);
      md(parity_t'(p), 1'b0, 1'b1);
      frame(d, parity_t'(p), 1'b0, 1'b0, 2'h2);
      rd(OFS_BUF, 1'b1, {24'h0, d});
      frame(d, parity_t'(p), 1'b1, 1'b0, bad ? 2'h1 : 2'h2);
      rd(OFS_STATUS, 1'b1, bad ? 32'h4 : 32'h0);
      rd(OFS_STATUS, 1'b1, 32'h0);
      rd(OFS_BUF, 1'b0, 32'h0);
    end
    bus(1'b0, OFS_MODE, 32'ha0);                         // seven data bits, no parity
    frame({1'b1, d[6:0]}, PAR_NONE, 1'b0, 1'b0, 2'h2);
    rd(OFS_BUF, 1'b1, {25'h0, d[6:0]});
    md(PAR_EVEN, 1'b1, 1'b1);
    frame(d, PAR_EVEN, 1'b0, 1'b1, 2'h2);
    rd(OFS_STATUS, 1'b1, 32'h2);
    rd(OFS_BUF, 1'b0, 32'h0);
    md(PAR_NONE, 1'b0, 1'b1);
    spikes = 1'b1;
    frame(d, PAR_NONE, 1'b0, 1'b0, 2'h2);
    spikes = 1'b0;
    frame(~d, PAR_NONE, 1'b0, 1'b0, 2'h1);
    rd(OFS_BUF, 1'b1, {24'h0, d});
    rd(OFS_STATUS, 1'b1, 32'h1);
    tx.glitch();
    repeat (60) @(posedge sys_clk);
    fork
      tx.send(~d, PAR_NONE, 1'b0, 1'b0, 1'b0);
      begin
        repeat (80) @(posedge sys_clk);
        md(PAR_NONE, 1'b0, 1'b0);
      end
    join
    frame(8'h5a, PAR_NONE, 1'b0, 1'b0, 2'h0);
    rd(OFS_BUF, 1'b1, {24'h0, d});
    rd(OFS_STATUS, 1'b1, 32'h0);
    if (irqQ.size() != 0) begin
      bad_count++;
      $display("MISMATCH %0t expected interrupt missing", $time);
    end
    final_report();
  end
  // cuts a hang short
  initial begin
    #1000000;
    bad_count++;
    $display("MISMATCH %0t timeout", $time);
    final_report();
  end
endmodule
